// >>> hw/pfpc_pkg.sv
// Purpose: constants for the pack switch protection controller
// Assumes: mclk at 125 MHz, synchronous active-high reset
// Notes: thresholds and qualification delays are inputs; widths, reset values, slot indices and the fuse wait live here
// Behaviour
// - low cell or cold: precharge on, charge off
// - all cells good, warm: charge also on
// - safety cutoff or temperature: charge, precharge low
// - charging above thresholds enables discharge switch too
// - discharging keeps charge on if current direction correct
// - discharge drive defaults high
// - low cell, overcurrent or fault: discharge low
// - programmable hysteresis on voltage limits
// - independent qualification timer per over-temperature/over-current threshold
// - safety current comparators act without firmware
// - external input polarity selectable
// - safety mode: external input forces switches off
// - alternate mode: inputs are platform power controls
// - switch fails to open on a fault or external input: blow fuse
// - ship mode opens all switches
// - extreme undervoltage: only precharge, when charger present
package pfpc_pkg;
  localparam int unsigned PFPC_CELLS = 4;
  localparam int unsigned PFPC_VW = 16;
  localparam int unsigned PFPC_TW = 16;
  localparam int unsigned PFPC_NQ = 4;
  localparam logic PFPC_DSG_RESET = 1'b1;
  localparam logic PFPC_CHG_RESET = 1'b0;
  localparam logic PFPC_PRE_RESET = 1'b0;
  localparam logic PFPC_PLAT_RESET = 1'b0;
  localparam logic PFPC_FUSE_RESET = 1'b0;
  // qualification slots: 0 chg over-temp, 1 dsg over-temp, 2 chg over-current, 3 dsg over-current
  localparam int unsigned PFPC_Q_OTC = 0;
  localparam int unsigned PFPC_Q_OTD = 1;
  localparam int unsigned PFPC_Q_OCC = 2;
  localparam int unsigned PFPC_Q_OCD = 3;
  // fuse escalation wait, given in microseconds and converted to cycles of mclk
  localparam int unsigned PFPC_FUSE_WAIT_US = 100;
  localparam int unsigned PFPC_FUSE_WAIT_CYC = PFPC_FUSE_WAIT_US * 125;
endpackage : pfpc_pkg

// >>> hw/pfpc_qual.sv
// Purpose: condition qualification timer
// Assumes: raw condition synchronous to mclk
// Notes: output asserts once raw held for limit cycles; drops with raw
`timescale 1ns/100ps
`default_nettype none
module pfpc_qual #(
  parameter int unsigned W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic raw,
  input wire logic [W-1:0] limit,
  output logic qualified
);
  logic [W-1:0] count;
  wire logic done = (count >= limit);
  // count while raw, hold at limit; any gap restarts the wait
  always_ff @(posedge mclk) begin
    if (rst || !raw) begin
      count <= '0;
      qualified <= 1'b0;
    end else begin
      if (!done) count <= count + 1'b1;
      qualified <= done;
    end
  end
endmodule : pfpc_qual
`default_nettype wire

// >>> hw/pfpc_top.sv
// Purpose: charge, precharge and discharge switch drive decision
// Assumes: all inputs synchronous to mclk; converters are outside
// Notes: drives are registered; fuse output is sticky until reset
//   ship mode overrides extreme undervoltage, which overrides normal use
`timescale 1ns/100ps
`default_nettype none
module pfpc_top
  import pfpc_pkg::*;
#(
  parameter int unsigned FUSE_WAIT = PFPC_FUSE_WAIT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [PFPC_CELLS*PFPC_VW-1:0] cell_mv,
  input wire logic [PFPC_VW-1:0] pack_mv,
  input wire logic [PFPC_VW-1:0] temp_k,
  input wire logic [PFPC_VW-1:0] precharge_uv_mv,
  input wire logic [PFPC_VW-1:0] cell_uv_mv,
  input wire logic [PFPC_VW-1:0] cell_ov_mv,
  input wire logic [PFPC_VW-1:0] pack_uv_mv,
  input wire logic [PFPC_VW-1:0] pack_ov_mv,
  input wire logic [PFPC_VW-1:0] hyst_mv,
  input wire logic [PFPC_VW-1:0] temp_chg_min,
  input wire logic [PFPC_VW-1:0] temp_chg_max,
  input wire logic [PFPC_VW-1:0] temp_dsg_max,
  input wire logic [PFPC_NQ*PFPC_TW-1:0] qual_limit,
  input wire logic charging,
  input wire logic discharging,
  input wire logic current_dir_ok,
  input wire logic charger_present,
  input wire logic safety_sense_cell_side,
  input wire logic safety_sense_pack_side,
  input wire logic short_circuit,
  input wire logic fw_fault,
  input wire logic ship_mode,
  input wire logic extreme_undervoltage_shutdown,
  input wire logic [1:0] external_switch_control_in,
  input wire logic [1:0] ext_polarity,
  input wire logic ext_mode_platform,
  output logic charge_switch_drive,
  output logic precharge_switch_drive,
  output logic discharge_switch_drive,
  output logic platform_power_ctl_a,
  output logic platform_power_ctl_b,
  output logic fuse_blow
);
  // per-cell comparisons
  // the release compares add the hysteresis, so a band near full scale wraps
  logic [PFPC_CELLS-1:0] below_pre;
  logic [PFPC_CELLS-1:0] below_uv;
  logic [PFPC_CELLS-1:0] above_ov;
  logic [PFPC_CELLS-1:0] above_uv_rel;
  logic [PFPC_CELLS-1:0] below_ov_rel;
  genvar g;
  generate
    for (g = 0; g < PFPC_CELLS; g++) begin : g_cell
      wire logic [PFPC_VW-1:0] v = cell_mv[g*PFPC_VW +: PFPC_VW];
      assign below_pre[g] = v < precharge_uv_mv;
      assign below_uv[g] = v < cell_uv_mv;
      assign above_ov[g] = v > cell_ov_mv;
      assign above_uv_rel[g] = v >= cell_uv_mv + hyst_mv;
      assign below_ov_rel[g] = v + hyst_mv <= cell_ov_mv;
    end
  endgenerate

  // pack-level limits; release needs the limit plus the hysteresis band
  wire logic pack_uv_set = pack_mv < pack_uv_mv;
  wire logic pack_ov_set = pack_mv > pack_ov_mv;
  wire logic pack_uv_clr = pack_mv >= pack_uv_mv + hyst_mv;
  wire logic pack_ov_clr = pack_mv + hyst_mv <= pack_ov_mv;

  // a latch sets on any cell or the pack and clears only when every one is back
  wire logic uv_set = |below_uv || pack_uv_set;
  wire logic ov_set = |above_ov || pack_ov_set;
  wire logic uv_clr = &above_uv_rel && pack_uv_clr;
  wire logic ov_clr = &below_ov_rel && pack_ov_clr;

  // latched voltage faults so drives do not chatter at a limit; set beats clear
  logic uv_flt;
  logic ov_flt;
  wire logic next_uv_flt = uv_set ? 1'b1 : (uv_clr ? 1'b0 : uv_flt);
  wire logic next_ov_flt = ov_set ? 1'b1 : (ov_clr ? 1'b0 : ov_flt);

  // under-voltage latch
  always_ff @(posedge mclk) begin
    if (rst) begin
      uv_flt <= 1'b0;
    end else begin
      uv_flt <= next_uv_flt;
    end
  end

  // over-voltage latch
  always_ff @(posedge mclk) begin
    if (rst) begin
      ov_flt <= 1'b0;
    end else begin
      ov_flt <= next_ov_flt;
    end
  end

  // each over-temperature and over-current limit has its own timer
  wire logic [PFPC_NQ-1:0] q_raw;
  logic [PFPC_NQ-1:0] q_ok;
  assign q_raw[PFPC_Q_OTC] = charging && (temp_k > temp_chg_max);
  assign q_raw[PFPC_Q_OTD] = temp_k > temp_dsg_max;
  assign q_raw[PFPC_Q_OCC] = safety_sense_cell_side;
  assign q_raw[PFPC_Q_OCD] = safety_sense_pack_side;
  generate
    for (g = 0; g < PFPC_NQ; g++) begin : g_qual
      pfpc_qual #(.W(PFPC_TW)) u_qual (
        .mclk(mclk),
        .rst(rst),
        .raw(q_raw[g]),
        .limit(qual_limit[g*PFPC_TW +: PFPC_TW]),
        .qualified(q_ok[g])
      );
    end
  endgenerate

  // external inputs, normalised to active high
  wire logic [1:0] ext_act = external_switch_control_in ^ ext_polarity;
  wire logic ext_force_off = !ext_mode_platform && |ext_act;
  wire logic [1:0] next_plat = ext_mode_platform ? ext_act : 2'b00;

  // fault aggregation; short circuit bypasses any timer
  wire logic temp_flt = q_ok[PFPC_Q_OTC] || q_ok[PFPC_Q_OTD];
  wire logic cur_flt = q_ok[PFPC_Q_OCC] || q_ok[PFPC_Q_OCD] || short_circuit;
  wire logic chg_kill = ov_flt || temp_flt || cur_flt || fw_fault || ext_force_off;
  wire logic dsg_kill = uv_flt || cur_flt || fw_fault || ext_force_off || temp_flt;
  wire logic cold = temp_k < temp_chg_min;
  wire logic pre_mode = |below_pre || cold;

  // enabling terms; precharge stays on beside charge once cells are good
  wire logic chg_en = (!pre_mode && !discharging) ||
                      (discharging && current_dir_ok);
  wire logic pre_en = !discharging;

  // normal-operation drives: any disable beats any enable
  // discharge is on by default, which also spares its body diode while charging
  wire logic norm_chg = chg_en && !chg_kill;
  wire logic norm_pre = pre_en && !chg_kill;
  wire logic norm_dsg = !dsg_kill;

  // extreme undervoltage keeps only precharge, and only with a charger present;
  // the external safety inputs still win because they act in pure hardware
  wire logic extreme_undervoltage_shutdown_pre = charger_present && !ext_force_off;

  // mode overrides: ship beats extreme undervoltage, which beats normal operation
  logic next_chg;
  logic next_pre;
  logic next_dsg;
  always_comb begin
    next_chg = norm_chg;
    next_pre = norm_pre;
    next_dsg = norm_dsg;
    if (extreme_undervoltage_shutdown) begin
      next_chg = 1'b0;
      next_dsg = 1'b0;
      next_pre = extreme_undervoltage_shutdown_pre;
    end
    if (ship_mode) begin
      next_chg = 1'b0;
      next_pre = 1'b0;
      next_dsg = 1'b0;
    end
  end

  // escalation: current still flows in the commanded direction after an open;
  // the count saturates so a long fault cannot wrap back below the wait
  logic [31:0] fail_cnt;
  wire logic open_cmd = ext_force_off || chg_kill || dsg_kill;
  wire logic still_on = open_cmd && current_dir_ok && (charging || discharging);
  wire logic fail_cnt_full = fail_cnt >= FUSE_WAIT;
  wire logic [31:0] fail_cnt_inc = fail_cnt + 32'h00000001;
  wire logic [31:0] next_fail_cnt = !still_on ? 32'h00000000 :
                                    (fail_cnt_full ? fail_cnt : fail_cnt_inc);
  wire logic next_fuse = fuse_blow || (still_on && fail_cnt_full);

  // timer of the escalation path
  always_ff @(posedge mclk) begin
    if (rst) begin
      fail_cnt <= '0;
    end else begin
      fail_cnt <= next_fail_cnt;
    end
  end

  // the fuse is one-way: once blown only reset clears the flag
  always_ff @(posedge mclk) begin
    if (rst) begin
      fuse_blow <= PFPC_FUSE_RESET;
    end else begin
      fuse_blow <= next_fuse;
    end
  end

  // registered drives, so a comparator glitch never reaches a gate;
  // the outer buffers invert, so a high drive here closes the switch
  always_ff @(posedge mclk) begin
    if (rst) begin
      charge_switch_drive <= PFPC_CHG_RESET;
      precharge_switch_drive <= PFPC_PRE_RESET;
      discharge_switch_drive <= PFPC_DSG_RESET;
    end else begin
      charge_switch_drive <= next_chg;
      precharge_switch_drive <= next_pre;
      discharge_switch_drive <= next_dsg;
    end
  end

  // platform power-management lines, live only in the alternate mode
  always_ff @(posedge mclk) begin
    if (rst) begin
      platform_power_ctl_a <= PFPC_PLAT_RESET;
      platform_power_ctl_b <= PFPC_PLAT_RESET;
    end else begin
      platform_power_ctl_a <= next_plat[0];
      platform_power_ctl_b <= next_plat[1];
    end
  end
endmodule : pfpc_top
`default_nettype wire

// >>> test/pfpc_fet_model.sv
// Purpose: external charge, precharge and discharge switches
// Assumes: inverting buffers, so a high drive closes a switch
// Notes: stuck freezes the switches to mimic a welded part
`timescale 1ns/100ps
`default_nettype none
module pfpc_fet_model (
  input wire logic mclk,
  input wire logic gate_chg,
  input wire logic gate_pre,
  input wire logic gate_dsg,
  input wire logic stuck,
  output logic flow
);
  logic [2:0] closed;
  // a welded switch ignores its gate, which is what the fuse path must catch
  always_ff @(posedge mclk) begin
    if (!stuck) begin
      closed <= {gate_chg, gate_pre, gate_dsg};
    end
  end
  assign flow = |closed;
endmodule : pfpc_fet_model
`default_nettype wire

// >>> test/pfpc_properties.sv
// Purpose: timing checks on the switch drive outputs
// Assumes: one clock, synchronous reset
// Notes: drives follow their inputs one edge later
`timescale 1ns/100ps
`default_nettype none
module pfpc_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic discharging,
  input wire logic charger_present,
  input wire logic short_circuit,
  input wire logic ship_mode,
  input wire logic extreme_undervoltage_shutdown,
  input wire logic [1:0] external_switch_control_in,
  input wire logic [1:0] ext_polarity,
  input wire logic ext_mode_platform,
  input wire logic charge_switch_drive,
  input wire logic precharge_switch_drive,
  input wire logic discharge_switch_drive,
  input wire logic platform_power_ctl_a,
  input wire logic fuse_blow
);
  logic act_q;
  wire logic ext_hit = |(external_switch_control_in ^ ext_polarity);
  // expected platform line, one edge behind its input
  always_ff @(posedge mclk) begin
    act_q <= external_switch_control_in[0] ^ ext_polarity[0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ship_all_off: assert property (ship_mode |=> !charge_switch_drive &&
    !precharge_switch_drive && !discharge_switch_drive) else $error("ship drive on");
  a_extreme_undervoltage_shutdown_main_off: assert property (extreme_undervoltage_shutdown |=>
    !charge_switch_drive && !discharge_switch_drive) else $error("extreme_undervoltage_shutdown drive on");
  a_extreme_undervoltage_shutdown_pre_on: assert property (extreme_undervoltage_shutdown && !ship_mode
    && charger_present && (ext_mode_platform || !ext_hit) |=> precharge_switch_drive)
    else $error("extreme_undervoltage_shutdown precharge off");
  a_short_dsg_off: assert property (short_circuit |=> !discharge_switch_drive)
    else $error("discharge on in short");
  a_ext_kill_all: assert property (!ext_mode_platform && ext_hit && !ship_mode
    |=> !(charge_switch_drive | precharge_switch_drive | discharge_switch_drive))
    else $error("external input ignored");
  a_plat_line_map: assert property (ext_mode_platform ##1 ext_mode_platform
    |-> platform_power_ctl_a == act_q) else $error("platform line wrong");
  a_pre_not_dsg: assert property (discharging && !extreme_undervoltage_shutdown
    |=> !precharge_switch_drive) else $error("precharge on while discharging");
  a_fuse_sticky: assert property (fuse_blow |=> fuse_blow) else $error("fuse dropped");
  c_ship: cover property (ship_mode ##1 !discharge_switch_drive);
  c_fuse: cover property ($rose(fuse_blow));
  c_plat: cover property (ext_mode_platform && platform_power_ctl_a);
endmodule : pfpc_properties
bind pfpc_top pfpc_properties i_pfpc_properties (.*);
`default_nettype wire

// >>> test/testbench.sv
// Purpose: self-checking bench for the switch drive decision
// Assumes: FUSE_WAIT shortened to 8 cycles
// Notes: expected drive triples are {charge, precharge, discharge}
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pfpc_pkg::*;
  logic mclk, rst, charging, discharging, dir_ok, charger_present, short_circuit, fw_fault;
  logic safety_sense_cell_side, safety_sense_pack_side, ship_mode, ext_mode_platform, stuck;
  logic extreme_undervoltage_shutdown, flow, platform_power_ctl_a, platform_power_ctl_b;
  logic charge_switch_drive, precharge_switch_drive, discharge_switch_drive, fuse_blow;
  logic [PFPC_CELLS*PFPC_VW-1:0] cell_mv;
  logic [PFPC_VW-1:0] pack_mv, temp_k, precharge_uv_mv, cell_uv_mv, cell_ov_mv, pack_uv_mv;
  logic [PFPC_VW-1:0] pack_ov_mv, hyst_mv, temp_chg_min, temp_chg_max, temp_dsg_max;
  logic [PFPC_NQ*PFPC_TW-1:0] qual_limit;
  logic [1:0] external_switch_control_in, ext_polarity;
  wire logic current_dir_ok = dir_ok & flow;
  int n_errors, num_checks, cyc;
  pfpc_top #(.FUSE_WAIT(8)) i_pfpc_top (.*);
  pfpc_fet_model i_pfpc_fet_model (.mclk, .gate_chg(charge_switch_drive),
    .gate_pre(precharge_switch_drive), .gate_dsg(discharge_switch_drive), .stuck, .flow);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, seen);
    end
  endtask : chk
  // four edges cover the two-stage voltage latch path with margin
  task automatic settle(input logic [2:0] exp, input logic [2:0] m, input string nm);
    repeat (4) @(posedge mclk);
    #1 chk(nm, {charge_switch_drive, precharge_switch_drive, discharge_switch_drive} & m, exp & m);
  endtask : settle
  task automatic reset_dut(input int n);
    @(posedge mclk) rst <= 1'b1;
    repeat (n) @(posedge mclk);
    #1 chk("reset", {charge_switch_drive, precharge_switch_drive, discharge_switch_drive}, 3'b001);
    @(posedge mclk) rst <= 1'b0;
  endtask : reset_dut
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // hang guard, far above the length of the sequence
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    {rst, charging, dir_ok, charger_present} = 4'hF;
    {discharging, short_circuit, fw_fault, safety_sense_cell_side} = 4'h0;
    {safety_sense_pack_side, ship_mode, ext_mode_platform, stuck} = 4'h0;
    {extreme_undervoltage_shutdown, external_switch_control_in, ext_polarity} = 5'h00;
    cell_mv = {4{16'h0E10}};
    {pack_mv, temp_k, precharge_uv_mv, cell_uv_mv} = {16'h3840, 16'h012C, 16'h0BB8, 16'h09C4};
    {cell_ov_mv, pack_uv_mv, pack_ov_mv, hyst_mv} = {16'h10CC, 16'h2710, 16'h4330, 16'h0064};
    {temp_chg_min, temp_chg_max, temp_dsg_max} = {16'h0111, 16'h013E, 16'h014D};
    qual_limit = {4{16'h0005}};
    reset_dut(8);
    settle(3'b111, 3'b111, "charging");
    @(posedge mclk) cell_mv[31:16] <= 16'h0AF0;
    settle(3'b011, 3'b111, "low cell");
    @(posedge mclk) {cell_mv[31:16], temp_k} <= {16'h0E10, 16'h00FA};
    settle(3'b011, 3'b111, "cold");
    @(posedge mclk) {temp_k, charging, discharging} <= {16'h012C, 2'b01};
    settle(3'b101, 3'b111, "discharging");
    @(posedge mclk) dir_ok <= 1'b0;
    settle(3'b000, 3'b100, "wrong direction");
    @(posedge mclk) {charging, discharging, dir_ok, cell_mv[15:0]} <= {3'b101, 16'h1130};
    settle(3'b000, 3'b110, "over voltage");
    @(posedge mclk) cell_mv <= {16'h0E10, 16'h0960, 16'h0E10, 16'h0E10};
    settle(3'b000, 3'b001, "under voltage");
    @(posedge mclk) cell_mv[47:32] <= 16'h0A27;
    settle(3'b000, 3'b001, "inside hysteresis");
    @(posedge mclk) cell_mv[47:32] <= 16'h0A28;
    settle(3'b001, 3'b001, "past hysteresis");
    @(posedge mclk) {cell_mv, short_circuit} <= {{4{16'h0E10}}, 1'b1};
    settle(3'b000, 3'b001, "short circuit");
    @(posedge mclk) short_circuit <= 1'b0;
    reset_dut(2);
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk) {ext_polarity, external_switch_control_in} <= {{2{p[0]}}, ~{2{p[0]}}};
      settle(3'b000, 3'b111, "external active");
      @(posedge mclk) external_switch_control_in <= {2{p[0]}};
      settle(3'b111, 3'b111, "external idle");
    end
    @(posedge mclk) {ext_mode_platform, ext_polarity, external_switch_control_in} <= 5'h11;
    settle(3'b111, 3'b111, "platform drives");
    chk("platform lines", {1'b0, platform_power_ctl_a, platform_power_ctl_b}, 3'b010);
    @(posedge mclk) {ext_mode_platform, external_switch_control_in, safety_sense_cell_side} <= 4'h1;
    repeat (3) @(posedge mclk);
    safety_sense_cell_side <= 1'b0;
    settle(3'b111, 3'b111, "short surge");
    @(posedge mclk) safety_sense_cell_side <= 1'b1;
    repeat (12) @(posedge mclk);
    #1 chk("long surge", {2'b00, charge_switch_drive & discharge_switch_drive}, 3'b000);
    @(posedge mclk) {safety_sense_cell_side, safety_sense_pack_side} <= 2'b01;
    repeat (8) @(posedge mclk);
    settle(3'b000, 3'b111, "pack surge");
    @(posedge mclk) safety_sense_pack_side <= 1'b0;
    settle(3'b111, 3'b111, "surge clear");
    @(posedge mclk) temp_k <= 16'h0190;
    repeat (8) @(posedge mclk);
    settle(3'b000, 3'b111, "over temp");
    @(posedge mclk) {temp_k, ship_mode} <= {16'h012C, 1'b1};
    settle(3'b000, 3'b111, "ship");
    @(posedge mclk) {ship_mode, extreme_undervoltage_shutdown} <= 2'b01;
    settle(3'b010, 3'b111, "extreme_undervoltage_shutdown charger");
    @(posedge mclk) charger_present <= 1'b0;
    settle(3'b000, 3'b111, "extreme_undervoltage_shutdown no charger");
    @(posedge mclk) {extreme_undervoltage_shutdown, charger_present} <= 2'b01;
    reset_dut(2);
    @(posedge mclk) {stuck, fw_fault} <= 2'b11;
    repeat (20) @(posedge mclk);
    #1 chk("fuse", {2'b00, fuse_blow}, 3'b001);
    @(posedge mclk) {stuck, fw_fault} <= 2'b00;
    repeat (4) @(posedge mclk);
    #1 chk("fuse held", {2'b00, fuse_blow}, 3'b001);
    reset_dut(2);
    final_report();
  end
endmodule : testbench
`default_nettype wire
